/* design/rid_core.sv */
// Instruction decoder and executor of an 8-bit core with 14-bit words.
// Assumes file reads are combinational and that instruction data is valid
// one instruction cycle after insn_addr_ff changes.
`timescale 1ns/1ps
`default_nettype none
module rid_core (
    input  wire logic                        clk,
    input  wire logic                        reset_n,
    input  wire logic [rid_pkg::INSN_W-1:0]  insn_data,
    input  wire logic [rid_pkg::DATA_W-1:0]  file_rd_data,
    input  wire logic [rid_pkg::DATA_W-1:0]  pin_rd_data,
    input  wire logic                        prescale_on_timer,
    input  wire logic                        wake,
    output logic      [rid_pkg::PC_W-1:0]    insn_addr_ff,
    output logic      [rid_pkg::ADDR_W-1:0]  file_addr_ff,
    output logic      [rid_pkg::DATA_W-1:0]  file_wr_data_ff,
    output logic                             file_wr_en_ff,
    output logic      [rid_pkg::DATA_W-1:0]  acc_ff,
    output logic                             carry_flag_ff,
    output logic                             half_carry_flag_ff,
    output logic                             zero_flag_ff,
    output logic                             timeout_flag_ff,
    output logic                             powerdown_flag_ff,
    output logic                             standby_ff,
    output logic                             watchdog_clear_ff,
    output logic                             prescaler_clear_ff,
    output logic                             int_enable_set_ff
);
    logic [1:0]                 phase_ff;
    logic                       cyc_en;
    logic                       flush_ff;
    logic [rid_pkg::PC_W-1:0]   pc_ff;
    logic [rid_pkg::PC_W-1:0]   top_of_stack;
    logic [5:0]                 op;
    logic [rid_pkg::ADDR_W-1:0] faddr;
    logic                       dest;
    logic [2:0]                 bsel;
    logic [7:0]                 lit;
    logic [7:0]                 fval;
    logic [7:0]                 res;
    logic [8:0]                 sum;
    logic [4:0]                 hsum;
    logic                       wr_acc;
    logic                       wr_file;
    logic                       upd_z;
    logic                       upd_c;
    logic                       upd_dc;
    logic                       nxt_c;
    logic                       skip;
    logic                       jump;
    logic [rid_pkg::PC_W-1:0]   jump_pc;
    logic                       push;
    logic                       pop;
    logic                       do_sleep;
    logic                       do_wdt;
    logic                       exec;

    // Port addresses whose reads come from pins.
    function automatic logic is_port(input logic [rid_pkg::ADDR_W-1:0] a);
        return (a == rid_pkg::ADDR_PORTA) || (a == rid_pkg::ADDR_SECOND_IO_PORT) ||
               (a == rid_pkg::ADDR_PORTC) || (a == rid_pkg::ADDR_PORTD) ||
               (a == rid_pkg::ADDR_PORTE);
    endfunction : is_port

    assign op     = insn_data[rid_pkg::OP_HI:rid_pkg::OP_LO];
    assign faddr  = insn_data[rid_pkg::ADDR_W-1:0];
    assign dest   = insn_data[rid_pkg::DEST_BIT];
    assign bsel   = insn_data[rid_pkg::BIT_HI:rid_pkg::BIT_LO];
    assign lit    = insn_data[7:0];
    assign cyc_en = (phase_ff == rid_pkg::PHASE_LAST);
    assign exec   = cyc_en && !flush_ff && !standby_ff;
    assign fval   = is_port(faddr) ? pin_rd_data : file_rd_data;

    // Instruction-cycle divider: one enable every four clocks.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_ff <= 2'h0;
        end else begin
            phase_ff <= phase_ff + 2'h1;
        end
    end

    always_comb begin
        res     = 8'h00;
        sum     = 9'h000;
        hsum    = 5'h00;
        wr_acc  = 1'b0;
        wr_file = 1'b0;
        upd_z   = 1'b0;
        upd_c   = 1'b0;
        upd_dc  = 1'b0;
        nxt_c   = carry_flag_ff;
        skip    = 1'b0;
        jump    = 1'b0;
        jump_pc = pc_ff;
        push    = 1'b0;
        pop     = 1'b0;
        do_sleep = 1'b0;
        do_wdt  = 1'b0;
        case (insn_data[13:12])
            2'b00: begin
                wr_acc  = !dest;
                wr_file = dest;
                case (op)
                    rid_pkg::OP_MISC: begin
                        wr_acc  = 1'b0;
                        wr_file = dest;
                        res     = acc_ff;
                        if (insn_data == rid_pkg::CODE_RETURN) begin
                            jump = 1'b1;
                            pop  = 1'b1;
                            jump_pc = top_of_stack;
                        end else if (insn_data == rid_pkg::CODE_INTERRUPT_RETURN) begin
                            jump = 1'b1;
                            pop  = 1'b1;
                            jump_pc = top_of_stack;
                        end else if (insn_data == rid_pkg::CODE_WDTCLR) begin
                            do_wdt = 1'b1;
                        end else if (insn_data == rid_pkg::CODE_SLEEP) begin
                            do_sleep = 1'b1;
                        end
                    end
                    rid_pkg::OP_CLR: begin
                        res   = 8'h00;
                        upd_z = 1'b1;
                    end
                    rid_pkg::OP_SUBTRACT_ACC_FROM_FILE: begin
                        sum    = {1'b0, fval} + {1'b0, ~acc_ff} + 9'h001;
                        hsum   = {1'b0, fval[3:0]} + {1'b0, ~acc_ff[3:0]} + 5'h01;
                        res    = sum[7:0];
                        upd_z  = 1'b1;
                        upd_c  = 1'b1;
                        upd_dc = 1'b1;
                        nxt_c  = sum[8];
                    end
                    rid_pkg::OP_DECF: begin
                        res   = fval - 8'h01;
                        upd_z = 1'b1;
                    end
                    rid_pkg::OP_OR_ACC_WITH_FILE: begin
                        res   = acc_ff | fval;
                        upd_z = 1'b1;
                    end
                    rid_pkg::OP_AND_ACC_WITH_FILE: begin
                        res   = acc_ff & fval;
                        upd_z = 1'b1;
                    end
                    rid_pkg::OP_XOR_ACC_WITH_FILE: begin
                        res   = acc_ff ^ fval;
                        upd_z = 1'b1;
                    end
                    rid_pkg::OP_ADD_ACC_TO_FILE: begin
                        sum    = {1'b0, acc_ff} + {1'b0, fval};
                        hsum   = {1'b0, acc_ff[3:0]} + {1'b0, fval[3:0]};
                        res    = sum[7:0];
                        upd_z  = 1'b1;
                        upd_c  = 1'b1;
                        upd_dc = 1'b1;
                        nxt_c  = sum[8];
                    end
                    rid_pkg::OP_COPY_FILE: begin
                        res   = fval;
                        upd_z = 1'b1;
                    end
                    rid_pkg::OP_COMPLEMENT_FILE: begin
                        res   = ~fval;
                        upd_z = 1'b1;
                    end
                    rid_pkg::OP_INCF: begin
                        res   = fval + 8'h01;
                        upd_z = 1'b1;
                    end
                    rid_pkg::OP_DECSZ: begin
                        res  = fval - 8'h01;
                        skip = (res == 8'h00);
                    end
                    rid_pkg::OP_RRF: begin
                        res   = {carry_flag_ff, fval[7:1]};
                        upd_c = 1'b1;
                        nxt_c = fval[0];
                    end
                    rid_pkg::OP_RLF: begin
                        res   = {fval[6:0], carry_flag_ff};
                        upd_c = 1'b1;
                        nxt_c = fval[7];
                    end
                    rid_pkg::OP_SWAP: begin
                        res = {fval[3:0], fval[7:4]};
                    end
                    rid_pkg::OP_INCSZ: begin
                        res  = fval + 8'h01;
                        skip = (res == 8'h00);
                    end
                    default: begin
                        res = fval;
                    end
                endcase
            end
            2'b01: begin
                res = fval;
                case (insn_data[11:10])
                    2'b00: begin
                        res[bsel] = 1'b0;
                        wr_file   = 1'b1;
                    end
                    2'b01: begin
                        res[bsel] = 1'b1;
                        wr_file   = 1'b1;
                    end
                    2'b10: begin
                        skip = !fval[bsel];
                    end
                    default: begin
                        skip = fval[bsel];
                    end
                endcase
            end
            2'b10: begin
                jump    = 1'b1;
                push    = !insn_data[11];
                jump_pc = {pc_ff[12:11], insn_data[10:0]};
            end
            default: begin
                wr_acc = 1'b1;
                case (insn_data[11:10])
                    2'b00: begin
                        res = lit;
                    end
                    2'b01: begin
                        res     = lit;
                        jump    = 1'b1;
                        pop     = 1'b1;
                        jump_pc = top_of_stack;
                    end
                    2'b10: begin
                        case (op)
                            rid_pkg::OP_OR_LITERAL_OP: res = acc_ff | lit;
                            rid_pkg::OP_AND_LITERAL_OP: res = acc_ff & lit;
                            rid_pkg::OP_XOR_LITERAL_OP: res = acc_ff ^ lit;
                            default: res = acc_ff;
                        endcase
                        upd_z  = (op != 6'h3b);
                        wr_acc = (op != 6'h3b);
                    end
                    default: begin
                        if (insn_data[9]) begin
                            sum  = {1'b0, acc_ff} + {1'b0, lit};
                            hsum = {1'b0, acc_ff[3:0]} + {1'b0, lit[3:0]};
                        end else begin
                            sum  = {1'b0, lit} + {1'b0, ~acc_ff} + 9'h001;
                            hsum = {1'b0, lit[3:0]} + {1'b0, ~acc_ff[3:0]} + 5'h01;
                        end
                        res    = sum[7:0];
                        upd_z  = 1'b1;
                        upd_c  = 1'b1;
                        upd_dc = 1'b1;
                        nxt_c  = sum[8];
                    end
                endcase
            end
        endcase
    end

    // A taken branch or true skip flushes the next fetch as a NOP.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            flush_ff <= 1'b0;
        end else if (cyc_en && !standby_ff) begin
            flush_ff <= exec && (jump || skip);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pc_ff        <= rid_pkg::RESET_PC;
            insn_addr_ff <= rid_pkg::RESET_PC;
        end else if (exec && jump) begin
            pc_ff        <= jump_pc;
            insn_addr_ff <= jump_pc;
        end else if (cyc_en && !standby_ff) begin
            pc_ff        <= pc_ff + 13'h0001;
            insn_addr_ff <= pc_ff;
        end
    end

    rid_stack u_stack (
        .clk       (clk),
        .reset_n   (reset_n),
        .push      (exec && push),
        .pop       (exec && pop),
        .push_data (pc_ff),
        .top_ff    (top_of_stack)
    );

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            acc_ff <= 8'h00;
        end else if (exec && wr_acc) begin
            acc_ff <= res;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            file_addr_ff       <= 7'h00;
            file_wr_data_ff    <= 8'h00;
            file_wr_en_ff      <= 1'b0;
            prescaler_clear_ff <= 1'b0;
        end else begin
            file_addr_ff       <= faddr;
            file_wr_data_ff    <= res;
            file_wr_en_ff      <= exec && wr_file;
            prescaler_clear_ff <= exec && wr_file && prescale_on_timer &&
                                  (faddr == rid_pkg::ADDR_TIMER0);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            carry_flag_ff      <= 1'b0;
            half_carry_flag_ff <= 1'b0;
            zero_flag_ff       <= 1'b0;
        end else if (exec) begin
            if (upd_c) begin
                carry_flag_ff <= nxt_c;
            end
            if (upd_dc) begin
                half_carry_flag_ff <= hsum[4];
            end
            if (upd_z) begin
                zero_flag_ff <= (res == 8'h00);
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            timeout_flag_ff   <= 1'b1;
            powerdown_flag_ff <= 1'b1;
            standby_ff        <= 1'b0;
            watchdog_clear_ff <= 1'b0;
            int_enable_set_ff <= 1'b0;
        end else begin
            watchdog_clear_ff <= exec && (do_wdt || do_sleep);
            int_enable_set_ff <= exec && (insn_data == rid_pkg::CODE_INTERRUPT_RETURN);
            if (exec && do_wdt) begin
                timeout_flag_ff   <= 1'b1;
                powerdown_flag_ff <= 1'b1;
            end else if (exec && do_sleep) begin
                timeout_flag_ff   <= 1'b1;
                powerdown_flag_ff <= 1'b0;
                standby_ff        <= 1'b1;
            end else if (wake) begin
                standby_ff <= 1'b0;
            end
        end
    end
endmodule : rid_core
`default_nettype wire

/* design/rid_pkg.sv */
// Constants for the 14-bit instruction decoder and executor.
// Assumes a single 250 MHz clock and an external file-register space.
package rid_pkg;
    localparam int DATA_W   = 8;
    localparam int ADDR_W   = 7;
    localparam int PC_W     = 13;
    localparam int INSN_W   = 14;
    localparam int STACK_D  = 8;
    // Q-phase divider: four clocks per instruction cycle.
    localparam logic [1:0] PHASE_LAST = 2'h3;
    // Opcode field positions.
    localparam int OP_HI      = 13;
    localparam int OP_LO      = 8;
    localparam int DEST_BIT   = 7;
    localparam int BIT_HI     = 9;
    localparam int BIT_LO     = 7;
    localparam logic [PC_W-1:0] RESET_PC = 13'h0000;
    // Byte-oriented opcodes, top six bits.
    localparam logic [5:0] OP_MISC  = 6'h00;
    localparam logic [5:0] OP_CLR   = 6'h01;
    localparam logic [5:0] OP_SUBTRACT_ACC_FROM_FILE = 6'h02;
    localparam logic [5:0] OP_DECF  = 6'h03;
    localparam logic [5:0] OP_OR_ACC_WITH_FILE = 6'h04;
    localparam logic [5:0] OP_AND_ACC_WITH_FILE = 6'h05;
    localparam logic [5:0] OP_XOR_ACC_WITH_FILE = 6'h06;
    localparam logic [5:0] OP_ADD_ACC_TO_FILE = 6'h07;
    localparam logic [5:0] OP_COPY_FILE  = 6'h08;
    localparam logic [5:0] OP_COMPLEMENT_FILE  = 6'h09;
    localparam logic [5:0] OP_INCF  = 6'h0a;
    localparam logic [5:0] OP_DECSZ = 6'h0b;
    localparam logic [5:0] OP_RRF   = 6'h0c;
    localparam logic [5:0] OP_RLF   = 6'h0d;
    localparam logic [5:0] OP_SWAP  = 6'h0e;
    localparam logic [5:0] OP_INCSZ = 6'h0f;
    // Literal opcodes.
    localparam logic [5:0] OP_OR_LITERAL_OP = 6'h38;
    localparam logic [5:0] OP_AND_LITERAL_OP = 6'h39;
    localparam logic [5:0] OP_XOR_LITERAL_OP = 6'h3a;
    // Fixed control codes.
    localparam logic [13:0] CODE_RETURN = 14'h0008;
    localparam logic [13:0] CODE_INTERRUPT_RETURN = 14'h0009;
    localparam logic [13:0] CODE_WDTCLR = 14'h0064;
    localparam logic [13:0] CODE_SLEEP  = 14'h0063;
    // Special file addresses.
    localparam logic [6:0] ADDR_TIMER0 = 7'h01;
    localparam logic [6:0] ADDR_PCL    = 7'h02;
    localparam logic [6:0] ADDR_PORTA  = 7'h05;
    localparam logic [6:0] ADDR_SECOND_IO_PORT  = 7'h06;
    localparam logic [6:0] ADDR_PORTC  = 7'h07;
    localparam logic [6:0] ADDR_PORTD  = 7'h08;
    localparam logic [6:0] ADDR_PORTE  = 7'h09;
endpackage : rid_pkg

/* design/rid_stack.sv */
// Return-address stack with registered top-of-stack output.
// Assumes push and pop are never asserted together; wraps when full.
`timescale 1ns/1ps
`default_nettype none
module rid_stack #(
    parameter int DEPTH = rid_pkg::STACK_D,
    parameter int WIDTH = rid_pkg::PC_W
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             push,
    input  wire logic             pop,
    input  wire logic [WIDTH-1:0] push_data,
    output logic      [WIDTH-1:0] top_ff
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0]    ptr_ff;
    logic [PW-1:0]    nxt_ptr;

    always_comb begin
        nxt_ptr = ptr_ff;
        if (push) begin
            nxt_ptr = ptr_ff + 1'b1;
        end else if (pop) begin
            nxt_ptr = ptr_ff - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ptr_ff <= '0;
        end else begin
            ptr_ff <= nxt_ptr;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mem_ff <= '{default: '0};
        end else if (push) begin
            mem_ff[nxt_ptr] <= push_data;
        end
    end

    // Top of stack is loaded on the same clock edge that moves the pointer.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            top_ff <= '0;
        end else if (push) begin
            top_ff <= push_data;
        end else begin
            top_ff <= mem_ff[nxt_ptr];
        end
    end
endmodule : rid_stack
`default_nettype wire

/* sim/rid_mem_model.sv */
// Program memory and file-register model for the decoder.
// Assumes the bench loads pmem and fmem between runs while reset is held.
`timescale 1ns/1ps
`default_nettype none
module rid_mem_model (
    input  wire logic        clk,
    input  wire logic [12:0] insn_addr,
    input  wire logic [6:0]  wr_addr,
    input  wire logic [7:0]  wr_data,
    input  wire logic        wr_en,
    output logic      [13:0] insn_data,
    output logic      [7:0]  rd_data
);
    logic [13:0] pmem [0:31];
    logic [7:0]  fmem [0:127];
    logic [12:0] addr_q;
    logic [1:0]  age = 2'h0;
    // The word is inverted from the first until the third clock after the address moves.
    always @(posedge clk) begin
        addr_q <= insn_addr;
        if (addr_q != insn_addr) age <= 2'h0;
        else if (age != 2'h2) age <= age + 2'h1;
        if (wr_en) fmem[wr_addr] <= wr_data;
    end
    assign insn_data = (age == 2'h2) ? pmem[insn_addr[4:0]] : ~pmem[insn_addr[4:0]];
    assign rd_data   = fmem[insn_data[6:0]];
endmodule : rid_mem_model
`default_nettype wire

/* sim/rid_core_asserts.sv */
// Port assertions for the decoder core.
// Assumes one clock domain with an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module rid_core_asserts (
    input wire logic                       clk,
    input wire logic                       reset_n,
    input wire logic                       prescale_on_timer,
    input wire logic [rid_pkg::PC_W-1:0]   insn_addr_ff,
    input wire logic [rid_pkg::ADDR_W-1:0] file_addr_ff,
    input wire logic                       file_wr_en_ff,
    input wire logic [rid_pkg::DATA_W-1:0] acc_ff,
    input wire logic                       timeout_flag_ff,
    input wire logic                       powerdown_flag_ff,
    input wire logic                       standby_ff,
    input wire logic                       watchdog_clear_ff,
    input wire logic                       prescaler_clear_ff,
    input wire logic                       int_enable_set_ff
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    wb_keeps_acc_a: assert property (file_wr_en_ff |-> $stable(acc_ff))
        else $error("accumulator changed on a file write");
    presc_cause_a: assert property (file_wr_en_ff
        && file_addr_ff == rid_pkg::ADDR_TIMER0 && $past(prescale_on_timer)
        |-> prescaler_clear_ff)
        else $error("prescaler not cleared");
    presc_only_a: assert property (prescaler_clear_ff |-> file_wr_en_ff
        && file_addr_ff == rid_pkg::ADDR_TIMER0)
        else $error("stray prescaler clear");
    wd_flags_a: assert property (watchdog_clear_ff && !standby_ff
        |-> timeout_flag_ff && powerdown_flag_ff)
        else $error("watchdog clear flags wrong");
    sleep_flags_a: assert property ($rose(standby_ff)
        |-> watchdog_clear_ff && timeout_flag_ff && !powerdown_flag_ff)
        else $error("sleep flags wrong");
    standby_hold_a: assert property (standby_ff && $past(standby_ff) |-> $stable(insn_addr_ff))
        else $error("fetch moved in standby");
    pc_pace_a: assert property ($changed(insn_addr_ff) |=> $stable(insn_addr_ff)[*3])
        else $error("fetch address paced wrongly");
    acc_pace_a: assert property ($changed(acc_ff) |=> $stable(acc_ff)[*3])
        else $error("accumulator paced wrongly");
    inten_pulse_a: assert property (int_enable_set_ff |=> !int_enable_set_ff[*3])
        else $error("interrupt enable pulse too long");
endmodule : rid_core_asserts
bind rid_core rid_core_asserts u_chk (.clk(clk), .reset_n(reset_n),
    .prescale_on_timer(prescale_on_timer), .insn_addr_ff(insn_addr_ff),
    .file_addr_ff(file_addr_ff), .file_wr_en_ff(file_wr_en_ff), .acc_ff(acc_ff),
    .timeout_flag_ff(timeout_flag_ff), .powerdown_flag_ff(powerdown_flag_ff),
    .standby_ff(standby_ff), .watchdog_clear_ff(watchdog_clear_ff),
    .prescaler_clear_ff(prescaler_clear_ff), .int_enable_set_ff(int_enable_set_ff));
`default_nettype wire

/* sim/tb_risc_14bit_instruction_decoder.sv */
// Bench that runs one instruction per short program and checks the results.
// Assumes the memory model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module tb_risc_14bit_instruction_decoder;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        wake = 1'b0;
    logic        prescale_on_timer = 1'b1;
    logic [7:0]  pin_rd_data = 8'h3c;
    logic [13:0] insn_data;
    logic [12:0] insn_addr_ff;
    logic [6:0]  file_addr_ff;
    logic [7:0]  file_rd_data, file_wr_data_ff, acc_ff;
    logic        file_wr_en_ff, carry_flag_ff, half_carry_flag_ff, zero_flag_ff;
    logic        timeout_flag_ff, powerdown_flag_ff, standby_ff;
    logic        watchdog_clear_ff, prescaler_clear_ff, int_enable_set_ff;
    logic [3:0]  ev;
    int          err_count = 0;
    int          n_tests = 0;

    always #2 clk = ~clk;

    rid_core u_dut (.clk(clk), .reset_n(reset_n), .insn_data(insn_data),
        .file_rd_data(file_rd_data), .pin_rd_data(pin_rd_data),
        .prescale_on_timer(prescale_on_timer), .wake(wake), .insn_addr_ff(insn_addr_ff),
        .file_addr_ff(file_addr_ff), .file_wr_data_ff(file_wr_data_ff),
        .file_wr_en_ff(file_wr_en_ff), .acc_ff(acc_ff), .carry_flag_ff(carry_flag_ff),
        .half_carry_flag_ff(half_carry_flag_ff), .zero_flag_ff(zero_flag_ff),
        .timeout_flag_ff(timeout_flag_ff), .powerdown_flag_ff(powerdown_flag_ff),
        .standby_ff(standby_ff), .watchdog_clear_ff(watchdog_clear_ff),
        .prescaler_clear_ff(prescaler_clear_ff), .int_enable_set_ff(int_enable_set_ff));

    rid_mem_model u_mem (.clk(clk), .insn_addr(insn_addr_ff), .wr_addr(file_addr_ff),
        .wr_data(file_wr_data_ff), .wr_en(file_wr_en_ff), .insn_data(insn_data),
        .rd_data(file_rd_data));

    // Sticky record of the event pulses seen during one run.
    always @(posedge clk) begin
        if (!reset_n) ev <= 4'h0;
        else ev <= ev | {prescaler_clear_ff, watchdog_clear_ff, standby_ff, int_enable_set_ff};
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Presets flags and the accumulator, runs op, then marks 0x21 unless skipped.
    task automatic t(input logic [13:0] op, input logic [7:0] a, f, input logic p,
                     input logic [7:0] ew, ef, input logic [2:0] fl, input logic sk,
                     input logic [5:0] evx);
        int i;
        @(negedge clk);
        reset_n = 1'b0;
        for (i = 0; i < 32; i++) u_mem.pmem[i] = 14'h0000;
        u_mem.pmem[2] = p ? 14'h30ff : 14'h3000;
        u_mem.pmem[3] = p ? 14'h3e02 : 14'h3e00;
        u_mem.pmem[4] = {6'h30, a};
        u_mem.pmem[5] = op;
        u_mem.pmem[6] = 14'h1421;
        u_mem.pmem[7] = 14'h2807;
        u_mem.fmem[32] = f;
        u_mem.fmem[33] = 8'h00;
        u_mem.fmem[6] = 8'h00;
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        repeat (56) @(negedge clk);
        chk({8'h00, acc_ff}, {8'h00, ew});
        chk({8'h00, u_mem.fmem[32]}, {8'h00, ef});
        chk({13'h0000, carry_flag_ff, half_carry_flag_ff, zero_flag_ff}, {13'h0000, fl});
        chk({8'h00, u_mem.fmem[33]}, {15'h0000, !sk});
        chk({10'h000, ev, timeout_flag_ff, powerdown_flag_ff}, {10'h000, evx});
        $display("test %0d done", n_tests / 5);
    endtask : t

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up

    initial begin
        repeat (16) @(negedge clk);
        t(14'h0420, 8'h0f, 8'hf0, 1'h0, 8'hff, 8'hf0, 3'h0, 1'h0, 6'h03);
        t(14'h05a0, 8'h0f, 8'hf0, 1'h1, 8'h0f, 8'h00, 3'h7, 1'h0, 6'h03);
        t(14'h0620, 8'hff, 8'hff, 1'h1, 8'h00, 8'hff, 3'h7, 1'h0, 6'h03);
        t(14'h09a0, 8'h00, 8'h0f, 1'h0, 8'h00, 8'hf0, 3'h0, 1'h0, 6'h03);
        t(14'h0820, 8'h55, 8'h00, 1'h1, 8'h00, 8'h00, 3'h7, 1'h0, 6'h03);
        t(14'h03a0, 8'h00, 8'h01, 1'h1, 8'h00, 8'h00, 3'h7, 1'h0, 6'h03);
        t(14'h0ba0, 8'h00, 8'h01, 1'h1, 8'h00, 8'h00, 3'h6, 1'h1, 6'h03);
        t(14'h0b20, 8'h00, 8'h02, 1'h0, 8'h01, 8'h02, 3'h1, 1'h0, 6'h03);
        t(14'h0aa0, 8'h00, 8'hff, 1'h1, 8'h00, 8'h00, 3'h7, 1'h0, 6'h03);
        t(14'h0f20, 8'h00, 8'hff, 1'h1, 8'h00, 8'hff, 3'h6, 1'h1, 6'h03);
        t(14'h0da0, 8'h00, 8'h81, 1'h0, 8'h00, 8'h02, 3'h5, 1'h0, 6'h03);
        t(14'h0c20, 8'h00, 8'h02, 1'h1, 8'h81, 8'h02, 3'h2, 1'h0, 6'h03);
        t(14'h19a0, 8'h33, 8'hf7, 1'h1, 8'h33, 8'hf7, 3'h6, 1'h1, 6'h03);
        t(14'h19a0, 8'h33, 8'h08, 1'h1, 8'h33, 8'h08, 3'h6, 1'h0, 6'h03);
        t(14'h1fa0, 8'h33, 8'h80, 1'h0, 8'h33, 8'h80, 3'h1, 1'h1, 6'h03);
        t(14'h3e08, 8'hf8, 8'h00, 1'h0, 8'h00, 8'h00, 3'h7, 1'h0, 6'h03);
        t(14'h395f, 8'ha3, 8'h00, 1'h1, 8'h03, 8'h00, 3'h6, 1'h0, 6'h03);
        t(14'h3800, 8'h00, 8'h00, 1'h1, 8'h00, 8'h00, 3'h7, 1'h0, 6'h03);
        t(14'h3aff, 8'h0f, 8'h00, 1'h0, 8'hf0, 8'h00, 3'h0, 1'h0, 6'h03);
        t(14'h3c10, 8'h01, 8'h00, 1'h0, 8'h0f, 8'h00, 3'h4, 1'h0, 6'h03);
        t(14'h3c00, 8'h01, 8'h00, 1'h1, 8'hff, 8'h00, 3'h0, 1'h0, 6'h03);
        t(14'h30a5, 8'h00, 8'h00, 1'h1, 8'ha5, 8'h00, 3'h6, 1'h0, 6'h03);
        t(14'h3400, 8'h00, 8'h00, 1'h0, 8'h00, 8'h00, 3'h1, 1'h1, 6'h03);
        t(14'h0008, 8'h00, 8'h00, 1'h0, 8'h00, 8'h00, 3'h1, 1'h1, 6'h03);
        t(14'h0009, 8'h00, 8'h00, 1'h0, 8'h00, 8'h00, 3'h1, 1'h1, 6'h07);
        t(14'h0064, 8'h33, 8'h00, 1'h1, 8'h33, 8'h00, 3'h6, 1'h0, 6'h13);
        t(14'h0063, 8'h33, 8'h00, 1'h1, 8'h33, 8'h00, 3'h6, 1'h1, 6'h1a);
        t(14'h0806, 8'h00, 8'h00, 1'h1, 8'h3c, 8'h00, 3'h6, 1'h0, 6'h03);
        t(14'h0e81, 8'h33, 8'h00, 1'h1, 8'h33, 8'h00, 3'h6, 1'h0, 6'h23);
        t(14'h07a0, 8'h17, 8'he9, 1'h0, 8'h17, 8'h00, 3'h7, 1'h0, 6'h03);
        t(14'h13a0, 8'h33, 8'hc7, 1'h1, 8'h33, 8'h47, 3'h6, 1'h0, 6'h03);
        t(14'h17a0, 8'h33, 8'h0a, 1'h0, 8'h33, 8'h8a, 3'h1, 1'h0, 6'h03);
        t(14'h0220, 8'h01, 8'h10, 1'h0, 8'h0f, 8'h10, 3'h4, 1'h0, 6'h03);
        t(14'h0ea0, 8'h00, 8'h3c, 1'h1, 8'h00, 8'hc3, 3'h6, 1'h0, 6'h03);
        t(14'h01a0, 8'h55, 8'h55, 1'h1, 8'h55, 8'h00, 3'h7, 1'h0, 6'h03);
        t(14'h00a0, 8'h5a, 8'h00, 1'h1, 8'h5a, 8'h5a, 3'h6, 1'h0, 6'h03);
        t(14'h2006, 8'h33, 8'h00, 1'h1, 8'h33, 8'h00, 3'h6, 1'h0, 6'h03);
        wake = 1'b1;
        t(14'h0063, 8'h33, 8'h00, 1'h1, 8'h33, 8'h00, 3'h6, 1'h0, 6'h1a);
        prescale_on_timer = 1'b0;
        t(14'h0e81, 8'h33, 8'h00, 1'h1, 8'h33, 8'h00, 3'h6, 1'h0, 6'h03);
        wrap_up();
    end
endmodule : tb_risc_14bit_instruction_decoder
`default_nettype wire
